// >>> src/ravs_top.sv
`timescale 1ns/1ns
module ravs_top (
  // Clock and reset
  input  wire logic                         mclk_i,
  input  wire logic                         rst_n_i,
  // Fuses
  input  wire logic                         boot_reset_fuse_i,
  input  wire logic [ravs_pkg::PC_W-1:0]    boot_start_i,
  // Control register write and retire pulse from the core
  input  wire logic                         ctrl_we_i,
  input  wire logic                         vector_change_enable_i,
  input  wire logic                         vector_table_select_i,
  input  wire logic                         instr_done_i,
  // Interrupt request from the core's arbiter
  input  wire logic                         irq_req_i,
  input  wire logic [ravs_pkg::VEC_W-1:0]   irq_index_i,
  // Fetch logic
  output logic      [ravs_pkg::PC_W-1:0]    reset_addr_o,
  output logic      [ravs_pkg::PC_W-1:0]    vec_addr_o,
  output logic                              irq_take_o,
  output logic                              irq_block_o,
  output logic                              vector_table_select_o,
  output logic                              vector_change_enable_o
);

  typedef struct packed {
    ravs_pkg::ravs_state_e st;
    logic [2:0]            cnt;
    logic                  sel;
  } ravs_state_s;

  // Count step of the vector-change window
  localparam logic [2:0] CNT_ONE = 3'h1;

  ravs_state_s s_q;
  ravs_state_s s_d;
  logic [ravs_pkg::PC_W-1:0] vaddr;
  logic                      idx_ok;
  logic                      src_known;
  logic                      en_wr;
  logic                      sel_wr;
  logic                      win_last;

  // ----------------------------------------------------------------
  // Reset address
  // ----------------------------------------------------------------
  // Fuse is a static strap, so selection is combinational
  always_comb begin
    if (boot_reset_fuse_i == ravs_pkg::FUSE_PROGRAMMED) begin
      reset_addr_o = boot_start_i;
    end else begin
      reset_addr_o = ravs_pkg::RESET_ADDR;
    end
  end

  // ----------------------------------------------------------------
  // Control write decode
  // ----------------------------------------------------------------
  // The select bit is only taken from a write that clears the enable,
  // so a write that sets both bits cannot move the table by itself
  assign en_wr    = ctrl_we_i && vector_change_enable_i;
  assign sel_wr   = ctrl_we_i && !vector_change_enable_i;
  assign win_last = (s_q.cnt == CNT_ONE);

  // ----------------------------------------------------------------
  // Vector-change sequence
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    unique case (s_q.st)
      ravs_pkg::RAVS_IDLE: begin
        // The arming cycle itself counts as the first of the window
        if (en_wr) begin
          s_d.st  = ravs_pkg::RAVS_OPEN;
          s_d.cnt = ravs_pkg::CHANGE_WINDOW - CNT_ONE;
        end
      end
      ravs_pkg::RAVS_OPEN: begin
        // A second enable write here is ignored and the count runs on
        if (sel_wr) begin
          s_d.sel = vector_table_select_i;
          s_d.st  = ravs_pkg::RAVS_TRAIL;
        end else if (win_last) begin
          s_d.st  = ravs_pkg::RAVS_IDLE;
          s_d.cnt = 3'h0;
        end else begin
          s_d.cnt = s_q.cnt - CNT_ONE;
        end
      end
      ravs_pkg::RAVS_TRAIL: begin
        // Hold the block through the instruction after the write
        if (instr_done_i) begin
          s_d.st  = ravs_pkg::RAVS_IDLE;
          s_d.cnt = 3'h0;
        end
      end
      default: begin
        s_d.st  = ravs_pkg::RAVS_IDLE;
        s_d.cnt = 3'h0;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      s_q.st  <= ravs_pkg::RAVS_IDLE;
      s_q.cnt <= 3'h0;
      s_q.sel <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Status outputs
  // ----------------------------------------------------------------
  // Blocking does not touch the core's global enable flag; the arming
  // write is blocked combinationally in its own cycle
  assign irq_block_o            = (s_q.st != ravs_pkg::RAVS_IDLE) ||
                                  en_wr;
  assign vector_table_select_o  = s_q.sel;
  assign vector_change_enable_o = (s_q.st == ravs_pkg::RAVS_OPEN);

  // ----------------------------------------------------------------
  // Vector address
  // ----------------------------------------------------------------
  ravs_vec_addr u_vec (
    .table_high_i (s_q.sel),
    .boot_start_i (boot_start_i),
    .vec_index_i  (irq_index_i),
    .vec_addr_o   (vaddr)
  );

  // ----------------------------------------------------------------
  // Source map
  // ----------------------------------------------------------------
  // Zero-based index of each source; index zero is the reset entry and
  // the nominal address of a source is twice its index.
  // T8A is the first 8-bit timer, T8B the second
  localparam logic [ravs_pkg::VEC_W-1:0] IDX_EXTERNAL_REQUEST_0     = 5'h01;
  localparam logic [ravs_pkg::VEC_W-1:0] IDX_EXTERNAL_REQUEST_1     = 5'h02;
  localparam logic [ravs_pkg::VEC_W-1:0] IDX_PIN_CHANGE_REQUEST_0   = 5'h03;
  localparam logic [ravs_pkg::VEC_W-1:0] IDX_PIN_CHANGE_REQUEST_1   = 5'h04;
  localparam logic [ravs_pkg::VEC_W-1:0] IDX_PIN_CHANGE_REQUEST_2   = 5'h05;
  localparam logic [ravs_pkg::VEC_W-1:0] IDX_WATCHDOG_TIMEOUT       = 5'h06;
  localparam logic [ravs_pkg::VEC_W-1:0] IDX_T8B_MATCH_A            = 5'h07;
  localparam logic [ravs_pkg::VEC_W-1:0] IDX_T8B_MATCH_B            = 5'h08;
  localparam logic [ravs_pkg::VEC_W-1:0] IDX_T8B_WRAP               = 5'h09;
  localparam logic [ravs_pkg::VEC_W-1:0] IDX_T16_CAPTURE            = 5'h0a;
  localparam logic [ravs_pkg::VEC_W-1:0] IDX_T16_MATCH_A            = 5'h0b;
  localparam logic [ravs_pkg::VEC_W-1:0] IDX_T16_MATCH_B            = 5'h0c;
  localparam logic [ravs_pkg::VEC_W-1:0] IDX_T16_WRAP               = 5'h0d;
  localparam logic [ravs_pkg::VEC_W-1:0] IDX_T8A_MATCH_A            = 5'h0e;
  localparam logic [ravs_pkg::VEC_W-1:0] IDX_T8A_MATCH_B            = 5'h0f;
  localparam logic [ravs_pkg::VEC_W-1:0] IDX_T8A_WRAP               = 5'h10;
  localparam logic [ravs_pkg::VEC_W-1:0] IDX_SPI_TRANSFER_DONE      = 5'h11;
  localparam logic [ravs_pkg::VEC_W-1:0] IDX_RX_COMPLETE            = 5'h12;
  localparam logic [ravs_pkg::VEC_W-1:0] IDX_TX_DATA_REGISTER_EMPTY = 5'h13;
  localparam logic [ravs_pkg::VEC_W-1:0] IDX_TX_COMPLETE            = 5'h14;
  localparam logic [ravs_pkg::VEC_W-1:0] IDX_ADC_DONE               = 5'h15;
  localparam logic [ravs_pkg::VEC_W-1:0] IDX_EEPROM_IDLE            = 5'h16;
  localparam logic [ravs_pkg::VEC_W-1:0] IDX_COMPARATOR             = 5'h17;
  localparam logic [ravs_pkg::VEC_W-1:0] IDX_TWO_WIRE_INTERFACE     = 5'h18;
  localparam logic [ravs_pkg::VEC_W-1:0] IDX_PROGRAM_STORE_READY    = 5'h19;

  always_comb begin
    src_known = 1'b0;
    unique case (irq_index_i)
      IDX_EXTERNAL_REQUEST_0:     src_known = 1'b1;
      IDX_EXTERNAL_REQUEST_1:     src_known = 1'b1;
      IDX_PIN_CHANGE_REQUEST_0:   src_known = 1'b1;
      IDX_PIN_CHANGE_REQUEST_1:   src_known = 1'b1;
      IDX_PIN_CHANGE_REQUEST_2:   src_known = 1'b1;
      IDX_WATCHDOG_TIMEOUT:       src_known = 1'b1;
      IDX_T8B_MATCH_A:            src_known = 1'b1;
      IDX_T8B_MATCH_B:            src_known = 1'b1;
      IDX_T8B_WRAP:               src_known = 1'b1;
      IDX_T16_CAPTURE:            src_known = 1'b1;
      IDX_T16_MATCH_A:            src_known = 1'b1;
      IDX_T16_MATCH_B:            src_known = 1'b1;
      IDX_T16_WRAP:               src_known = 1'b1;
      IDX_T8A_MATCH_A:            src_known = 1'b1;
      IDX_T8A_MATCH_B:            src_known = 1'b1;
      IDX_T8A_WRAP:               src_known = 1'b1;
      IDX_SPI_TRANSFER_DONE:      src_known = 1'b1;
      IDX_RX_COMPLETE:            src_known = 1'b1;
      IDX_TX_DATA_REGISTER_EMPTY: src_known = 1'b1;
      IDX_TX_COMPLETE:            src_known = 1'b1;
      IDX_ADC_DONE:               src_known = 1'b1;
      IDX_EEPROM_IDLE:            src_known = 1'b1;
      IDX_COMPARATOR:             src_known = 1'b1;
      IDX_TWO_WIRE_INTERFACE:     src_known = 1'b1;
      IDX_PROGRAM_STORE_READY:    src_known = 1'b1;
      default:                    src_known = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Interrupt acceptance
  // ----------------------------------------------------------------
  // Index zero is the reset entry and is never taken as an interrupt;
  // the range guard keeps indices past the table out if the map grows
  assign idx_ok     = src_known && (irq_index_i < ravs_pkg::VEC_COUNT);
  assign irq_take_o = irq_req_i && idx_ok && !irq_block_o;
  assign vec_addr_o = irq_take_o ? vaddr : ravs_pkg::RESET_ADDR;

endmodule // ravs_top

// >>> src/ravs_pkg.sv
package ravs_pkg;

  // ----------------------------------------------------------------
  // Address widths and table layout
  // ----------------------------------------------------------------
  localparam int unsigned          PC_W           = 13;
  localparam int unsigned          VEC_W          = 5;
  localparam logic [VEC_W-1:0]     VEC_COUNT      = 5'h1a;
  localparam logic [PC_W-1:0]      RESET_ADDR     = 13'h0000;
  localparam logic [PC_W-1:0]      LOW_TABLE_BASE = 13'h0000;
  localparam logic [PC_W-1:0]      VEC_STRIDE     = 13'h0002;
  localparam logic [PC_W-1:0]      BOOT_START_DEF = 13'h1c00;

  // Fuse encoding: one means unprogrammed
  localparam logic                 FUSE_PROGRAMMED = 1'b0;

  // ----------------------------------------------------------------
  // Vector-change window
  // ----------------------------------------------------------------
  localparam logic [2:0]           CHANGE_WINDOW  = 3'h4;

  typedef enum logic [1:0] {
    RAVS_IDLE   = 2'b00,
    RAVS_OPEN   = 2'b01,
    RAVS_TRAIL  = 2'b11
  } ravs_state_e;

endpackage

// >>> src/ravs_vec_addr.sv
`timescale 1ns/1ns
module ravs_vec_addr (
  // Selection
  input  wire logic                         table_high_i,
  input  wire logic [ravs_pkg::PC_W-1:0]    boot_start_i,
  input  wire logic [ravs_pkg::VEC_W-1:0]   vec_index_i,
  // Result
  output logic      [ravs_pkg::PC_W-1:0]    vec_addr_o
);

  logic [ravs_pkg::PC_W-1:0] base;
  logic [ravs_pkg::PC_W-1:0] offs;

  always_comb begin
    base = table_high_i ? boot_start_i : ravs_pkg::LOW_TABLE_BASE;
    // Index 0 is reset, so index n lands at n times the stride
    offs = ravs_pkg::PC_W'(vec_index_i) * ravs_pkg::VEC_STRIDE;
    vec_addr_o = base + offs;
  end

endmodule // ravs_vec_addr

// >>> tb/ravs_top_monitor.sv
`timescale 1ns/1ns
module ravs_top_monitor (
  // Watched ports
  input wire logic        mclk_i,
  input wire logic        rst_n_i,
  input wire logic        boot_reset_fuse_i,
  input wire logic [12:0] boot_start_i,
  input wire logic        ctrl_we_i,
  input wire logic        vector_change_enable_i,
  input wire logic        vector_table_select_i,
  input wire logic        irq_req_i,
  input wire logic [4:0]  irq_index_i,
  input wire logic [12:0] reset_addr_o,
  input wire logic [12:0] vec_addr_o,
  input wire logic        irq_take_o,
  input wire logic        irq_block_o,
  input wire logic        vector_table_select_o,
  input wire logic        vector_change_enable_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  fuse_clear_a: assert property (boot_reset_fuse_i |-> reset_addr_o == 13'h0)
    else $error("reset address");
  fuse_set_a: assert property (!boot_reset_fuse_i |-> reset_addr_o == boot_start_i)
    else $error("boot reset address");
  low_vec_a: assert property (irq_take_o && !vector_table_select_o
    |-> vec_addr_o == {irq_index_i, 1'b0}) else $error("low vector");
  high_vec_a: assert property (irq_take_o && vector_table_select_o
    |-> vec_addr_o == boot_start_i + {irq_index_i, 1'b0}) else $error("high vector");
  take_cause_a: assert property (irq_take_o |-> irq_req_i && !irq_block_o
    && irq_index_i inside {[1:25]}) else $error("take");
  open_block_a: assert property (vector_change_enable_o |-> irq_block_o)
    else $error("open block");
  window_len_a: assert property (vector_change_enable_o [*3] |=> !vector_change_enable_o)
    else $error("window length");
  sel_guard_a: assert property (!vector_change_enable_o |=> $stable(vector_table_select_o))
    else $error("select guard");
  sel_write_a: assert property (ctrl_we_i && !vector_change_enable_i && vector_change_enable_o
    |=> vector_table_select_o == $past(vector_table_select_i)) else $error("select write");
endmodule // ravs_top_monitor

bind ravs_top ravs_top_monitor u_mon (.*);

// >>> tb/ravs_core_model.sv
`timescale 1ns/1ns
module ravs_core_model (
  // Clock and pacing
  input  wire logic mclk_i,
  input  wire logic slow_i,
  // Retire pulse
  output logic      instr_done_o
);
  logic [1:0] cnt_q = 2'h0;
  // Slow mode retires one in four, so a trailing block has to wait
  always_ff @(posedge mclk_i) cnt_q <= cnt_q + 2'h1;
  assign instr_done_o = !slow_i || cnt_q == 2'h0;
endmodule // ravs_core_model

// >>> tb/tb_ravs_top.sv
`timescale 1ns/1ns
module tb_ravs_top;
  logic mclk_i = 0, rst_n_i = 0, fuse = 1, we = 0, en = 0, sel = 0, req = 0, slow = 0;
  logic hi = 0, done, take, block, sel_o, en_o;
  logic [12:0] bs = 0, vec, ra, q[$];
  logic [4:0] idx = 0;
  int mismatches = 0, n_compared = 0, seed = 41089;
  ravs_top u_dut (.mclk_i, .rst_n_i, .boot_reset_fuse_i(fuse), .boot_start_i(bs),
    .ctrl_we_i(we), .vector_change_enable_i(en), .vector_table_select_i(sel),
    .instr_done_i(done), .irq_req_i(req), .irq_index_i(idx), .reset_addr_o(ra),
    .vec_addr_o(vec), .irq_take_o(take), .irq_block_o(block),
    .vector_table_select_o(sel_o), .vector_change_enable_o(en_o));
  ravs_core_model u_core (.mclk_i, .slow_i(slow), .instr_done_o(done));
  initial forever #10 mclk_i = ~mclk_i;
  task automatic chk(string n, logic [12:0] e, logic [12:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic sweep;
    for (int i = 0; i < 32; i++) begin
      @(posedge mclk_i);
      req <= 1;
      idx <= 5'(i);
      if (i inside {[1:25]}) q.push_back((hi ? bs : 13'h0) + 13'(i * 2));
    end
    @(posedge mclk_i);
    req <= 0;
  endtask
  task automatic wr(logic e, logic s);
    @(posedge mclk_i);
    we <= 1;
    en <= e;
    sel <= s;
    @(posedge mclk_i);
    we <= 0;
  endtask
  // Every take must match the oldest expected vector
  always @(negedge mclk_i) if (take === 1'b1) begin
    if (q.size() == 0) chk("take", 0, 1);
    else chk("vector", q.pop_front(), vec);
  end
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    final_report;
  end
  initial begin
    bs <= 13'($random(seed));
    repeat (8) @(posedge mclk_i);
    rst_n_i <= 1;
    @(negedge mclk_i);
    chk("reset addr", 0, ra);
    @(posedge mclk_i);
    fuse <= 0;
    @(negedge mclk_i);
    chk("boot addr", bs, ra);
    sweep;
    slow <= 1;
    @(posedge mclk_i);
    we <= 1;
    en <= 1;
    req <= 1;
    idx <= 1;
    @(posedge mclk_i);
    we <= 0;
    wr(0, 1);
    req <= 0;
    for (int k = 0; k < 20 && block !== 1'b0; k++) @(negedge mclk_i);
    chk("block", 0, 13'(block));
    chk("select", 1, 13'(sel_o));
    hi = 1;
    sweep;
    wr(0, 0);
    @(negedge mclk_i);
    chk("select kept", 1, 13'(sel_o));
    wr(1, 0);
    repeat (3) @(negedge mclk_i);
    chk("block held", 1, 13'(block));
    chk("window open", 1, 13'(en_o));
    @(negedge mclk_i);
    chk("block end", 0, 13'(block));
    chk("window shut", 0, 13'(en_o));
    sweep;
    repeat (2) @(negedge mclk_i);
    chk("queue", 0, 13'(q.size()));
    final_report;
  end
endmodule // tb_ravs_top
